/* File: logic/fxm_pkg.sv */
`default_nettype none
package fxm_pkg;
    localparam int ACC_W   = 80;
    localparam int WORD_W  = 32;
    localparam int EXT_W   = 8;
    localparam int REG_W   = WORD_W + EXT_W;
    localparam int RIDX_W  = 4;
    localparam int UPPER_W = 16;
    localparam int ROUND_BIT = 32;
    localparam int OV_SF   = 33;
    localparam int OV_SI   = 49;
    localparam int OV_UF   = 32;
    localparam int OV_UI   = 48;
    localparam int UF_HI   = 48;
    localparam int UF_LO   = 32;
    localparam logic [3:0] SEL_FG_LOW = 4'h0;
    localparam logic [3:0] SEL_FG_MID = 4'h1;
    localparam logic [3:0] SEL_FG_UP  = 4'h2;
    localparam logic [3:0] SEL_BG_LOW = 4'h4;
    localparam logic [3:0] SEL_BG_MID = 4'h5;
    localparam logic [3:0] SEL_BG_UP  = 4'h6;
    localparam logic [ACC_W-1:0] ACC_RST = 80'h0;

    typedef enum logic [2:0]
    {
        FXM_OP_NOP   = 3'b000,
        FXM_OP_MUL   = 3'b001,
        FXM_OP_MAC   = 3'b010,
        FXM_OP_MSU   = 3'b011,
        FXM_OP_CLAMP = 3'b100,
        FXM_OP_ROUND = 3'b101,
        FXM_OP_CLR   = 3'b110,
        FXM_OP_XFER  = 3'b111
    } fxm_op_t;
endpackage
`default_nettype wire

/* File: logic/fxm_flag_eval.sv */
`timescale 1ns/10ps
`default_nettype none
module fxm_flag_eval
    import fxm_pkg::*;
(
    input  wire logic [ACC_W-1:0] res,
    input  wire logic             frac,
    input  wire logic             sgn,
    output logic                  neg,
    output logic                  ovf,
    output logic                  unf
);
    wire [OV_SI-1:0] top_si = res[ACC_W-1 -: OV_SI];
    wire [OV_SF-1:0] top_sf = res[ACC_W-1 -: OV_SF];
    wire [OV_UI-1:0] top_ui = res[ACC_W-1 -: OV_UI];
    wire [OV_UF-1:0] top_uf = res[ACC_W-1 -: OV_UF];
    wire [UF_HI-1:0] uf_hi  = res[ACC_W-1 -: UF_HI];
    wire             ov_s   = frac ? !(&top_sf || !(|top_sf)) : !(&top_si || !(|top_si));
    wire             ov_u   = frac ? |top_uf : |top_ui;
    wire             hi_ok  = !(|uf_hi) || (sgn && &uf_hi);

    // unsigned data has no sign, so top bit only means negative when signed
    assign neg = sgn & res[ACC_W-1];
    assign ovf = sgn ? ov_s : ov_u;
    assign unf = frac & hi_ok & (|res[UF_LO-1:0]);
endmodule // fxm_flag_eval
`default_nettype wire

/* File: logic/fxm_mac_unit.sv */
`timescale 1ns/10ps
`default_nettype none
module fxm_mac_unit
    import fxm_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              op_valid,
    input  wire logic [2:0]        op_code,
    input  wire logic              src_bg,
    input  wire logic              dst_is_reg,
    input  wire logic [RIDX_W-1:0] dst_reg_idx,
    input  wire logic              fmt_frac,
    input  wire logic              x_signed,
    input  wire logic              y_signed,
    input  wire logic              round_req,
    input  wire logic [REG_W-1:0]  x_operand,
    input  wire logic [REG_W-1:0]  y_operand_register,
    input  wire logic [3:0]        accum_select_field,
    input  wire logic              xfer_dir,
    input  wire logic [REG_W-1:0]  transfer_data_register,
    output logic                   rf_we,
    output logic [RIDX_W-1:0]      rf_idx,
    output logic [REG_W-1:0]       rf_wdata,
    output logic                   mult_negative_flag,
    output logic                   mult_overflow_flag,
    output logic                   mult_underflow_flag,
    output logic                   mult_invalid_flag,
    output logic [ACC_W-1:0]       foreground_accumulator,
    output logic [ACC_W-1:0]       background_accumulator
);
    fxm_op_t op;
    assign op = fxm_op_t'(op_code);

    logic [ACC_W-1:0] fg_ff;
    logic [ACC_W-1:0] bg_ff;
    logic             n_ff;
    logic             v_ff;
    logic             u_ff;
    logic             i_ff;
    logic             we_ff;
    logic [RIDX_W-1:0] idx_ff;
    logic [REG_W-1:0] wd_ff;

    // source and destination are the same accumulator by issuer contract
    wire [ACC_W-1:0] acc_in = src_bg ? bg_ff : fg_ff;

    wire [WORD_W-1:0] xw = x_operand[REG_W-1 -: WORD_W];
    wire [WORD_W-1:0] yw = y_operand_register[REG_W-1 -: WORD_W];
    wire signed [WORD_W:0] xs = {x_signed & xw[WORD_W-1], xw};
    wire signed [WORD_W:0] ys = {y_signed & yw[WORD_W-1], yw};
    wire signed [2*WORD_W+1:0] prod_raw = xs * ys;
    wire [ACC_W-1:0] prod_int = {{(ACC_W-2*WORD_W-2){prod_raw[2*WORD_W+1]}}, prod_raw};
    // fractional product is shifted left once to drop the redundant sign bit
    wire [ACC_W-1:0] prod = fmt_frac ? {prod_int[ACC_W-2:0], 1'b0} : prod_int;
    wire res_signed = x_signed | y_signed;

    wire [ACC_W-1:0] sum = acc_in + prod;
    wire [ACC_W-1:0] dif = acc_in - prod;
    wire [ACC_W-1:0] half = ACC_W'(1) << (ROUND_BIT - 1);
    wire [ACC_W-1:0] acc_round = acc_in + half;

    // saturate maximum: largest positive (signed) or all ones (unsigned) in the low 32 bits, or the low 64 bits when fractional
    wire [ACC_W-1:0] max_s = fmt_frac ? {16'h0, 1'b0, {(2*WORD_W-1){1'b1}}}
                                      : {48'h0, 1'b0, {(WORD_W-1){1'b1}}};
    wire [ACC_W-1:0] max_u = fmt_frac ? {16'h0, {(2*WORD_W){1'b1}}}
                                      : {48'h0, {WORD_W{1'b1}}};
    wire [ACC_W-1:0] clamp_max = x_signed ? max_s : max_u;
    wire clamp_gt = x_signed ? ($signed(acc_in) > $signed(clamp_max)) : (acc_in > clamp_max);
    wire [ACC_W-1:0] clamp_res = clamp_gt ? clamp_max : acc_in;

    logic [ACC_W-1:0] raw;
    always_comb
    begin
        unique case (op)
            FXM_OP_MAC:   raw = sum;
            FXM_OP_MSU:   raw = dif;
            FXM_OP_CLAMP: raw = clamp_res;
            FXM_OP_ROUND: raw = acc_round;
            default:      raw = prod;
        endcase
    end

    wire is_arith = (op == FXM_OP_MUL) || (op == FXM_OP_MAC) || (op == FXM_OP_MSU);
    // rounding only meaningful for fractional data; integer requests pass untouched
    wire do_round = is_arith & round_req & fmt_frac;
    wire [ACC_W-1:0] raw_r = raw + half;
    wire [ACC_W-1:0] res = do_round ? raw_r : raw;
    wire res_sgn = (op == FXM_OP_CLAMP || op == FXM_OP_ROUND) ? x_signed : res_signed;

    wire f_neg;
    wire f_ovf;
    wire f_unf;
    fxm_flag_eval u_flags
    (
        .res  (res),
        .frac (fmt_frac),
        .sgn  (res_sgn),
        .neg  (f_neg),
        .ovf  (f_ovf),
        .unf  (f_unf)
    );

    wire is_calc = is_arith || (op == FXM_OP_CLAMP) || (op == FXM_OP_ROUND);
    wire [WORD_W-1:0] res_word = fmt_frac ? res[2*WORD_W-1:WORD_W] : res[WORD_W-1:0];

    // transfer word decode
    wire sel_fg = (accum_select_field[3:2] == 2'b00) && (accum_select_field[1:0] != 2'b11);
    wire sel_bg = (accum_select_field[3:2] == 2'b01) && (accum_select_field[1:0] != 2'b11);
    wire [1:0] wsel = accum_select_field[1:0];
    wire [ACC_W-1:0] xacc = sel_bg ? bg_ff : fg_ff;
    logic [WORD_W-1:0] xword;
    always_comb
    begin
        unique case (accum_select_field)
            SEL_FG_LOW, SEL_BG_LOW: xword = xacc[WORD_W-1:0];
            SEL_FG_MID, SEL_BG_MID: xword = xacc[2*WORD_W-1:WORD_W];
            SEL_FG_UP, SEL_BG_UP:   xword = {{(WORD_W-UPPER_W){xacc[ACC_W-1]}},
                                             xacc[ACC_W-1:2*WORD_W]};
            default:                xword = '0;
        endcase
    end
    wire [WORD_W-1:0] tin = transfer_data_register[REG_W-1 -: WORD_W];
    // move into one word of an accumulator, other words kept
    wire [ACC_W-1:0] xnew = (wsel == 2'b00) ? {xacc[ACC_W-1:WORD_W], tin}
                          : (wsel == 2'b01) ? {xacc[ACC_W-1:2*WORD_W], tin, xacc[WORD_W-1:0]}
                          : {tin[UPPER_W-1:0], xacc[2*WORD_W-1:0]};
    wire xfer_ok = op_valid && (op == FXM_OP_XFER) && (sel_fg || sel_bg);
    wire xfer_in = xfer_ok && xfer_dir;

    wire acc_wr = op_valid && is_calc && !dst_is_reg;
    wire clr = op_valid && (op == FXM_OP_CLR);
    wire flag_upd = op_valid && is_calc;

    wire [ACC_W-1:0] nxt_fg = (clr && !src_bg) ? ACC_RST
                            : (acc_wr && !src_bg) ? res
                            : (xfer_in && sel_fg) ? xnew : fg_ff;
    wire [ACC_W-1:0] nxt_bg = (clr && src_bg) ? ACC_RST
                            : (acc_wr && src_bg) ? res
                            : (xfer_in && sel_bg) ? xnew : bg_ff;

    wire nxt_we = (op_valid && is_calc && dst_is_reg) || (xfer_ok && !xfer_dir);
    wire [RIDX_W-1:0] nxt_idx = dst_reg_idx;
    wire [REG_W-1:0] nxt_wd = (op == FXM_OP_XFER) ? {xword, {EXT_W{1'b0}}}
                                                  : {res_word, {EXT_W{1'b0}}};
    wire nxt_v = (op == FXM_OP_CLAMP) ? 1'b0 : f_ovf;
    wire nxt_i = (op == FXM_OP_ROUND) ? i_ff : 1'b0;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fg_ff <= ACC_RST;
            bg_ff <= ACC_RST;
        end
        else
        begin
            fg_ff <= nxt_fg;
            bg_ff <= nxt_bg;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            n_ff <= 1'b0;
            v_ff <= 1'b0;
            u_ff <= 1'b0;
            i_ff <= 1'b0;
        end
        else if (flag_upd)
        begin
            n_ff <= f_neg;
            v_ff <= nxt_v;
            u_ff <= f_unf;
            i_ff <= nxt_i;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            we_ff  <= 1'b0;
            idx_ff <= '0;
            wd_ff  <= '0;
        end
        else
        begin
            we_ff  <= nxt_we;
            idx_ff <= nxt_idx;
            wd_ff  <= nxt_wd;
        end
    end

    assign rf_we                  = we_ff;
    assign rf_idx                 = idx_ff;
    assign rf_wdata               = wd_ff;
    assign mult_negative_flag     = n_ff;
    assign mult_overflow_flag     = v_ff;
    assign mult_underflow_flag    = u_ff;
    assign mult_invalid_flag      = i_ff;
    assign foreground_accumulator = fg_ff;
    assign background_accumulator = bg_ff;
endmodule // fxm_mac_unit
`default_nettype wire

/* File: bench/fxm_rf_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fxm_rf_model
    import fxm_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              rf_we,
    input wire logic [RIDX_W-1:0] rf_idx,
    input wire logic [REG_W-1:0]  rf_wdata
);
    logic [REG_W-1:0] regs [16];

    always_ff @(posedge core_clk)
        if (rf_we)
            regs[rf_idx] <= rf_wdata;
endmodule // fxm_rf_model
`default_nettype wire

/* File: bench/fxm_mac_unit_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module fxm_mac_unit_assertions
    import fxm_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              rst_b,
    input wire logic              op_valid,
    input wire logic [2:0]        op_code,
    input wire logic              src_bg,
    input wire logic              dst_is_reg,
    input wire logic [RIDX_W-1:0] dst_reg_idx,
    input wire logic              fmt_frac,
    input wire logic              x_signed,
    input wire logic              y_signed,
    input wire logic [3:0]        accum_select_field,
    input wire logic              xfer_dir,
    input wire logic [REG_W-1:0]  transfer_data_register,
    input wire logic              rf_we,
    input wire logic [RIDX_W-1:0] rf_idx,
    input wire logic [REG_W-1:0]  rf_wdata,
    input wire logic              mult_negative_flag,
    input wire logic              mult_overflow_flag,
    input wire logic              mult_underflow_flag,
    input wire logic              mult_invalid_flag,
    input wire logic [ACC_W-1:0]  foreground_accumulator
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire logic mul_op = op_valid && op_code inside {[3'h1:3'h3]};
    wire logic xin_mid = op_valid && op_code == 3'h7 && xfer_dir && accum_select_field == 4'h1;

    property p_rf_echo;
        mul_op && dst_is_reg |=> rf_we && rf_idx == $past(dst_reg_idx);
    endproperty
    a_rf_echo: assert property (p_rf_echo) else $error("register write not issued");
    property p_ext_zero; rf_we |-> rf_wdata[7:0] == 8'h00; endproperty
    a_ext_zero: assert property (p_ext_zero) else $error("extension not zero");
    property p_int_unf; mul_op && !fmt_frac |=> !mult_underflow_flag; endproperty
    a_int_unf: assert property (p_int_unf) else $error("integer underflow seen");
    property p_inv_clr;
        op_valid && op_code inside {[3'h1:3'h4]} |=> !mult_invalid_flag;
    endproperty
    a_inv_clr: assert property (p_inv_clr) else $error("invalid flag not cleared");
    property p_round_inv; op_valid && op_code == 3'h5 |=> $stable(mult_invalid_flag); endproperty
    a_round_inv: assert property (p_round_inv) else $error("round changed invalid");
    property p_clamp_ovf; op_valid && op_code == 3'h4 |=> !mult_overflow_flag; endproperty
    a_clamp_ovf: assert property (p_clamp_ovf) else $error("saturate kept overflow");
    property p_clr;
        op_valid && op_code == 3'h6 && !src_bg |=> foreground_accumulator == 80'h0
            && $stable(mult_negative_flag) && $stable(mult_overflow_flag);
    endproperty
    a_clr: assert property (p_clr) else $error("clear wrong");
    property p_xin;
        xin_mid |=> foreground_accumulator[63:32] == $past(transfer_data_register[39:8]);
    endproperty
    a_xin: assert property (p_xin) else $error("word move in wrong");
    property p_neg;
        mul_op && op_code == 3'h1 && !dst_is_reg && !src_bg && x_signed && y_signed
            |=> mult_negative_flag == foreground_accumulator[79];
    endproperty
    a_neg: assert property (p_neg) else $error("negative flag wrong");
    c_mul: cover property (mul_op && dst_is_reg);
    c_xin: cover property (xin_mid);
    c_clr: cover property (op_valid && op_code == 3'h6);
endmodule // fxm_mac_unit_assertions
bind fxm_mac_unit fxm_mac_unit_assertions i_chk (.*);
`default_nettype wire

/* File: bench/fxm_mac_unit_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module fxm_mac_unit_tb
    import fxm_pkg::*;
;
    logic             core_clk, rst_b, op_valid, src_bg, dst_is_reg, fmt_frac, x_signed;
    logic             y_signed, round_req, xfer_dir, rf_we, mult_negative_flag;
    logic             mult_overflow_flag, mult_underflow_flag, mult_invalid_flag;
    logic [2:0]       op_code;
    logic [3:0]       dst_reg_idx, accum_select_field, rf_idx, flg;
    logic [REG_W-1:0] x_operand, y_operand_register, transfer_data_register, rf_wdata;
    logic [ACC_W-1:0] foreground_accumulator, background_accumulator;
    logic [3:0]       sel [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
    logic [31:0]      val [6] = '{32'h11112222, 32'h33334444, 32'hABCD5555,
                                  32'h66667777, 32'h00000001, 32'h12348001};
    int               n_fail, n_tests;

    assign flg = {mult_negative_flag, mult_overflow_flag, mult_underflow_flag, mult_invalid_flag};
    fxm_mac_unit i_dut (.*);
    fxm_rf_model i_rf (.core_clk(core_clk), .rf_we(rf_we), .rf_idx(rf_idx), .rf_wdata(rf_wdata));

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic test_done;
        if (n_fail == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // nonzero extension bits prove the datapath ignores them
    task automatic op(input logic [2:0] c, input logic bg, rg, fr, sg, rn,
                      input logic [31:0] x, y);
        @(negedge core_clk);
        {op_code, src_bg, dst_is_reg, fmt_frac} = {c, bg, rg, fr};
        {x_signed, y_signed, round_req} = {sg, sg, rn};
        x_operand = {x, 8'hA5};
        y_operand_register = {y, 8'h5A};
        op_valid = 1'b1;
        @(negedge core_clk);
        op_valid = 1'b0;
    endtask

    task automatic move_word(input logic d, input logic [3:0] s, input logic [31:0] v,
                             input logic [3:0] i);
        {xfer_dir, accum_select_field, dst_reg_idx} = {d, s, i};
        transfer_data_register = {v, 8'hFF};
        op(3'h7, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 32'h0);
    endtask

    initial
    begin
        {op_valid, op_code, src_bg, dst_is_reg, dst_reg_idx, fmt_frac, x_signed, y_signed,
         round_req, x_operand, y_operand_register, accum_select_field, xfer_dir,
         transfer_data_register} = '0;
        rst_b = 1'b0;
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        for (int i = 0; i < 6; i++)
            move_word(1'b1, sel[i], val[i], 4'h0);
        chk(foreground_accumulator, 80'h5555_33334444_11112222);
        chk(background_accumulator, 80'h8001_00000001_66667777);
        move_word(1'b1, 4'h3, 32'hDEADBEEF, 4'h0);
        chk(foreground_accumulator, 80'h5555_33334444_11112222);
        move_word(1'b0, 4'h6, 32'h0, 4'h9);
        // the register file takes the write one edge after the unit registers it
        @(negedge core_clk);
        chk(i_rf.regs[9], 40'hFFFF8001_00);
        move_word(1'b0, 4'h1, 32'h0, 4'h3);
        @(negedge core_clk);
        chk(i_rf.regs[3], 40'h33334444_00);
        move_word(1'b1, 4'h0, 32'h80000000, 4'h3);
        op(3'h5, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 32'h0, 32'h0);
        chk(foreground_accumulator[79:32], 48'h5555_33334445);
        chk(flg, 4'b0100);
        op(3'h6, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 32'h0);
        chk(foreground_accumulator, 80'h0);
        chk(flg, 4'b0100);
        // a negative value is never above the signed maximum
        op(3'h4, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 32'h0, 32'h0);
        chk(background_accumulator, 80'h8001_00000001_66667777);
        chk(flg, 4'b1000);
        op(3'h4, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 32'h0);
        chk(background_accumulator, 80'hFFFFFFFF);
        chk(flg, 4'b0000);
        op(3'h1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 32'hFFFFFFFD, 32'h5);
        chk(foreground_accumulator, 80'hFFFF_FFFFFFFF_FFFFFFF1);
        chk(flg, 4'b1000);
        op(3'h2, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 32'h4, 32'h5);
        chk(foreground_accumulator, 80'h5);
        op(3'h3, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 32'h2, 32'h3);
        chk(foreground_accumulator, {80{1'b1}});
        op(3'h1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 32'h10000, 32'h10000);
        @(negedge core_clk);
        chk(i_rf.regs[3], 40'h0);
        chk(flg, 4'b0100);
        op(3'h1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 32'h8000, 32'h8000);
        @(negedge core_clk);
        chk(i_rf.regs[3], 40'h00000001_00);
        chk(flg, 4'b0000);
        op(3'h1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 32'h8000, 32'h8000);
        @(negedge core_clk);
        chk(i_rf.regs[3], 40'h0);
        chk(flg, 4'b0010);
        op(3'h1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 32'h3, 32'h5);
        @(negedge core_clk);
        chk(i_rf.regs[3], 40'h0000000F_00);
        test_done();
    end

    initial
    begin
        #20000;
        n_fail++;
        test_done();
    end
endmodule // fxm_mac_unit_tb
`default_nettype wire
